// ===== dv/lsp_pad_model.sv
// Pads of the port plus the LCD common source that shares them
module lsp_pad_model (
   input  wire logic       hclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe_n,
   input  wire logic [7:0] ext_val,
   input  wire logic       ext_en,
   output logic      [7:0] pin_in,
   output logic      [7:0] lcd_common_in
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] cnt_q = 8'h00;

   // Commons change every cycle so a stale copy on a pin is caught
   always @(posedge hclk) begin
      cnt_q <= cnt_q + 8'h01;
      lcd_common_in <= cnt_q ^ 8'h5A;
   end

   // An open pad wanders; an unknown would settle by the tool's choice
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (!pin_oe_n[i]) begin
            pin_in[i] = pin_out[i];
         end else if (ext_en) begin
            pin_in[i] = ext_val[i];
         end else begin
            pin_in[i] = cnt_q[i];
         end
      end
   end
endmodule // lsp_pad_model

// ===== dv/lsp_port_tb_top.sv
module lsp_port_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0]  htrans = 2'h0;
   logic        hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   logic        rmw_access = 1'b0;
   logic        standby_entry = 1'b0;
   logic [7:0]  lcd_common_in, pin_in, pin_out, pin_oe_n, lvl;
   logic [7:0]  ext = 8'h00;
   logic        ext_en = 1'b1;
   logic [31:0] rd;
   logic [7:0]  d, r;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cyc = 0;

   always #10 hclk = ~hclk;

   lsp_port dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rmw_access(rmw_access), .standby_entry(standby_entry),
      .lcd_common_in(lcd_common_in), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe_n(pin_oe_n), .port_input_level(lvl));

   lsp_pad_model pad_u (.hclk(hclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .ext_val(ext), .ext_en(ext_en), .pin_in(pin_in), .lcd_common_in(lcd_common_in));

   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // Hang guard: the whole run needs well under 2000 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         test_done();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One AHB-Lite single transfer; waits on hready, never on a fixed count
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd,
                      input logic rmw);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      rmw_access <= rmw;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      rmw_access <= 1'b0;
      hwdata <= {24'h0, wd};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
      chk(hresp, 32'h0, "response");
   endtask

   task automatic settle;
      repeat (3) @(posedge hclk);
      @(negedge hclk);
   endtask

   // Data read: outputs give the latch, inputs the pad, rmw the latch
   function automatic logic [31:0] exp_rd(logic [7:0] dv, logic [7:0] dr,
                                          logic [7:0] e, logic rmw);
      return rmw ? {24'h0, dv} : {24'h0, (dv & dr) | (e & ~dr)};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(66523));
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(negedge hclk);
      chk(pin_oe_n, 8'hFF, "reset float");
      @(posedge hclk);
      bus(1'b0, 8'h04, 8'h00, 1'b0);
      chk(rd, 32'h0, "dir reset");
      $display("test reset done");

      for (int i = 0; i < 24; i++) begin
         d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
         r = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         ext <= 8'($urandom);
         bus(1'b1, 8'h00, d, 1'b0);
         bus(1'b1, 8'h04, r, 1'b0);
         settle();
         chk(pin_oe_n, {24'h0, ~r}, "direction");
         chk(pin_out & r, d & r, "output value");
         @(posedge hclk);
         bus(1'b0, 8'h00, 8'h00, 1'b0);
         chk(rd, exp_rd(d, r, ext, 1'b0), "plain read");
         bus(1'b0, 8'h00, 8'h00, 1'b1);
         chk(rd, exp_rd(d, r, ext, 1'b1), "rmw read");
         bus(1'b0, 8'h04, 8'h00, 1'b0);
         chk(rd, {24'h0, r}, "dir read");
         bus(1'b0, 8'h10, 8'h00, 1'b0);
         chk(rd, exp_rd(d, r, ext, 1'b0), "pin levels");
      end
      bus(1'b1, 8'h14, 8'hFF, 1'b0);
      bus(1'b0, 8'h14, 8'h00, 1'b0);
      chk(rd, 32'h0, "unmapped");
      $display("test gpio done");

      bus(1'b1, 8'h04, 8'h00, 1'b0);
      bus(1'b1, 8'h0C, 8'h81, 1'b0);
      bus(1'b1, 8'h08, 8'h02, 1'b0);
      settle();
      chk(pin_oe_n, 8'h7E, "lcd owns");
      chk({pin_out[7], pin_out[0]}, {lcd_common_in[7], lcd_common_in[0]}, "lcd");
      chk({lvl[7], lvl[0]}, 2'b00, "lcd blocks input");
      @(posedge hclk);
      bus(1'b0, 8'h0C, 8'h00, 1'b0);
      chk(rd, 32'h81, "common select read");
      bus(1'b0, 8'h08, 8'h00, 1'b0);
      chk(rd, 32'h2, "control read");
      bus(1'b1, 8'h0C, 8'h00, 1'b0);
      bus(1'b1, 8'h00, 8'h81, 1'b0);
      bus(1'b1, 8'h04, 8'h81, 1'b0);
      settle();
      chk(pin_oe_n, 8'h7E, "port again");
      chk(pin_out & 8'h81, 8'h81, "port again value");
      $display("test lcd done");

      @(posedge hclk);
      bus(1'b1, 8'h04, 8'hFF, 1'b0);
      bus(1'b1, 8'h00, 8'hA5, 1'b0);
      bus(1'b1, 8'h08, 8'h01, 1'b0);
      standby_entry <= 1'b1;
      ext_en <= 1'b0;
      settle();
      chk(pin_oe_n, 8'hFF, "standby float");
      chk(lvl, 8'h00, "standby blocked");
      @(posedge hclk);
      standby_entry <= 1'b0;
      ext_en <= 1'b1;
      bus(1'b1, 8'h08, 8'h00, 1'b0);
      standby_entry <= 1'b1;
      bus(1'b1, 8'h00, 8'h5A, 1'b0);
      settle();
      chk({pin_oe_n, pin_out}, 16'h00A5, "standby hold");
      @(posedge hclk);
      standby_entry <= 1'b0;
      settle();
      chk(pin_out, 8'h5A, "after standby");
      $display("test standby done");

      // Reset in mid-run with every pin an output
      @(posedge hclk);
      hresetn <= 1'b0;
      @(negedge hclk);
      chk({pin_oe_n, lvl}, 16'hFF00, "mid reset float");
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, 8'h04, 8'h00, 1'b0);
      chk(rd, 32'h0, "dir cleared");
      $display("test reset again done");
      test_done();
   end
endmodule // lsp_port_tb_top

// ===== rtl/lsp_consts.svh
`ifndef LSP_CONSTS_SVH
`define LSP_CONSTS_SVH

// Register byte offsets on the AHB-Lite word map
`define LSP_OFS_DATA        8'h00
`define LSP_OFS_DIR         8'h04
`define LSP_OFS_CTRL        8'h08
`define LSP_OFS_COMSEL      8'h0C
`define LSP_OFS_PINS        8'h10

// Fields of the control register
`define LSP_CTRL_FLOAT_BIT  0
`define LSP_CTRL_PORT_IN_BIT 1
`define LSP_CTRL_WIDTH      2

// Reset values
`define LSP_RST_DATA        8'h00
`define LSP_RST_DIR         8'h00
`define LSP_RST_CTRL        2'h0
`define LSP_RST_COMSEL      8'h00

// Number of decoded address bits
`define LSP_ADDR_BITS       8

`endif

// ===== rtl/lsp_pkg.sv
package lsp_pkg;

   // Bus slave sequencing
   typedef enum logic [1:0] {
      LSP_ST_IDLE,
      LSP_ST_WRITE,
      LSP_ST_RD_FETCH,
      LSP_ST_RD_DONE
   } lsp_bus_state_t;

endpackage

// ===== rtl/lsp_port.sv
// The register offsets and the AHB-Lite interface to the registers were chosen for this implementation.
`include "lsp_consts.svh"

module lsp_port #(
   parameter int PINS = 8
) (
   input  wire logic                              hclk,
   input  wire logic                              hresetn,
   input  wire logic                              hsel,
   input  wire logic [31:0]                       haddr,
   input  wire logic [1:0]                        htrans,
   input  wire logic                              hwrite,
   input  wire logic [2:0]                        hsize,
   input  wire logic [31:0]                       hwdata,
   input  wire logic                              hready,
   output logic      [31:0]                       hrdata,
   output logic                                   hreadyout,
   output logic                                   hresp,
   input  wire logic                              rmw_access,
   input  wire logic                              standby_entry,
   input  wire logic [PINS-1:0]                   lcd_common_in,
   input  wire logic [PINS-1:0]                   pin_in,
   output logic      [PINS-1:0]                   pin_out,
   output logic      [PINS-1:0]                   pin_oe_n,
   output logic      [PINS-1:0]                   port_input_level
);

   // Reset values and the read mux are sized for one byte of pins
   if (PINS < 1 || PINS > 8) begin : g_pins_check
      $error("lsp_port: PINS must lie between 1 and 8");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   function automatic logic reg_hit(input logic [`LSP_ADDR_BITS-1:0] addr,
                                    input logic [`LSP_ADDR_BITS-1:0] ofs);
      reg_hit = (addr == ofs);
   endfunction

   lsp_pkg::lsp_bus_state_t         state_q;
   logic [`LSP_ADDR_BITS-1:0]       addr_q;
   logic                            rmw_q;
   logic [PINS-1:0]                 data_q;
   logic [PINS-1:0]                 dir_q;
   logic [`LSP_CTRL_WIDTH-1:0]      ctrl_q;
   logic [PINS-1:0]                 comsel_q;
   logic [PINS-1:0]                 hold_out_q;
   logic [PINS-1:0]                 hold_oen_q;
   logic [31:0]                     hrdata_q;
   logic [PINS-1:0]                 pin_sync;
   logic [PINS-1:0]                 live_out;
   logic [PINS-1:0]                 live_oen;
   logic [PINS-1:0]                 data_read;
   logic [31:0]                     read_mux;
   logic                            addr_phase;
   logic                            float_en;
   logic                            lcd_port_input_control;

   assign float_en   = ctrl_q[`LSP_CTRL_FLOAT_BIT];
   assign lcd_port_input_control = ctrl_q[`LSP_CTRL_PORT_IN_BIT];
   assign addr_phase = hsel && htrans[1] && hready;

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave sequencing

   // Reads take one wait state so read data leaves a flip-flop and sees any
   // write that finished in the cycle before.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q <= lsp_pkg::LSP_ST_IDLE;
      end else begin
         case (state_q)
            lsp_pkg::LSP_ST_RD_FETCH: begin
               state_q <= lsp_pkg::LSP_ST_RD_DONE;
            end
            default: begin
               if (addr_phase && hwrite) begin
                  state_q <= lsp_pkg::LSP_ST_WRITE;
               end else if (addr_phase) begin
                  state_q <= lsp_pkg::LSP_ST_RD_FETCH;
               end else begin
                  state_q <= lsp_pkg::LSP_ST_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q <= '0;
         rmw_q  <= 1'b0;
      end else if (addr_phase) begin
         addr_q <= haddr[`LSP_ADDR_BITS-1:0];
         rmw_q  <= rmw_access;
      end
   end

   assign hreadyout = (state_q != lsp_pkg::LSP_ST_RD_FETCH);
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Registers

   // Latch takes writes in either direction; only the pin mux decides driving
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         data_q <= `LSP_RST_DATA;
      end else if (state_q == lsp_pkg::LSP_ST_WRITE && reg_hit(addr_q, `LSP_OFS_DATA)) begin
         data_q <= hwdata[PINS-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_q <= `LSP_RST_DIR;
      end else if (state_q == lsp_pkg::LSP_ST_WRITE && reg_hit(addr_q, `LSP_OFS_DIR)) begin
         dir_q <= hwdata[PINS-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q   <= `LSP_RST_CTRL;
         comsel_q <= `LSP_RST_COMSEL;
      end else if (state_q == lsp_pkg::LSP_ST_WRITE) begin
         if (reg_hit(addr_q, `LSP_OFS_CTRL)) begin
            ctrl_q <= hwdata[`LSP_CTRL_WIDTH-1:0];
         end
         if (reg_hit(addr_q, `LSP_OFS_COMSEL)) begin
            comsel_q <= hwdata[PINS-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin input path

   lsp_sync #(
      .WIDTH    (PINS)
   ) u_sync (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .async_in (pin_in),
      .sync_out (pin_sync)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Per-pin ownership and read value

   for (genvar i = 0; i < PINS; i++) begin : g_pin
      always_comb begin
         // LCD owns the pin only once port input control is on
         if (comsel_q[i] && lcd_port_input_control) begin
            live_out[i] = lcd_common_in[i];
            live_oen[i] = 1'b0;
         end else if (!comsel_q[i] && dir_q[i]) begin
            live_out[i] = data_q[i];
            live_oen[i] = 1'b0;
         end else begin
            live_out[i] = data_q[i];
            live_oen[i] = 1'b1;
         end
      end

      always_comb begin
         if (standby_entry && float_en) begin
            port_input_level[i] = 1'b0;
         end else if (comsel_q[i] && lcd_port_input_control) begin
            port_input_level[i] = 1'b0;
         end else begin
            port_input_level[i] = pin_sync[i];
         end
      end

      always_comb begin
         if (dir_q[i] || rmw_q) begin
            data_read[i] = data_q[i];
         end else begin
            data_read[i] = port_input_level[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Standby pin state

   // The hold copy tracks the live state until standby, then freezes it, so
   // an LCD signal changing during standby never reaches the pin.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_out_q <= '0;
         hold_oen_q <= '1;
      end else if (!standby_entry) begin
         hold_out_q <= live_out;
         hold_oen_q <= live_oen;
      end
   end

   always_comb begin
      if (standby_entry && float_en) begin
         pin_out  = hold_out_q;
         pin_oe_n = '1;
      end else if (standby_entry) begin
         pin_out  = hold_out_q;
         pin_oe_n = hold_oen_q;
      end else begin
         pin_out  = live_out;
         pin_oe_n = live_oen;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   always_comb begin
      read_mux = '0;
      if (reg_hit(addr_q, `LSP_OFS_DATA)) begin
         read_mux[PINS-1:0] = data_read;
      end else if (reg_hit(addr_q, `LSP_OFS_DIR)) begin
         read_mux[PINS-1:0] = dir_q;
      end else if (reg_hit(addr_q, `LSP_OFS_CTRL)) begin
         read_mux[`LSP_CTRL_WIDTH-1:0] = ctrl_q;
      end else if (reg_hit(addr_q, `LSP_OFS_COMSEL)) begin
         read_mux[PINS-1:0] = comsel_q;
      end else if (reg_hit(addr_q, `LSP_OFS_PINS)) begin
         read_mux[PINS-1:0] = port_input_level;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= '0;
      end else if (state_q == lsp_pkg::LSP_ST_RD_FETCH) begin
         hrdata_q <= read_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   dir_out_drive_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!standby_entry && !comsel_q[0] && dir_q[0]) |-> (!pin_oe_n[0] && pin_out[0] == data_q[0]))
      else $error("output pin not driving its latch bit");

   input_release_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!standby_entry && comsel_q == '0 && dir_q == '0) |-> (pin_oe_n == '1))
      else $error("input pin is being driven");

   write_latch_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (state_q == lsp_pkg::LSP_ST_WRITE && addr_q == `LSP_OFS_DATA)
         |=> (data_q == $past(hwdata[PINS-1:0])))
      else $error("data write did not reach the latch");

   read_output_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (state_q == lsp_pkg::LSP_ST_RD_FETCH && addr_q == `LSP_OFS_DATA)
         |=> ((hrdata[PINS-1:0] & $past(dir_q)) == ($past(data_q) & $past(dir_q))))
      else $error("output bit read did not return the latch");

   rmw_read_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (state_q == lsp_pkg::LSP_ST_RD_FETCH && addr_q == `LSP_OFS_DATA && rmw_q)
         |=> (hrdata[PINS-1:0] == $past(data_q)))
      else $error("read-modify-write read did not return the latch");

   float_block_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (standby_entry && float_en) |-> (pin_oe_n == '1 && port_input_level == '0))
      else $error("standby float left a pin driven or an input open");

   hold_level_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (standby_entry && !float_en && $past(standby_entry))
         |-> (pin_out == $past(pin_out) && pin_oe_n == $past(pin_oe_n)))
      else $error("pin state moved during standby hold");

   reset_dir_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      $rose(hresetn) |-> (dir_q == '0 && pin_oe_n == '1))
      else $error("direction not cleared by reset");

   lcd_route_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (!standby_entry && comsel_q[0] && lcd_port_input_control)
         |-> (!pin_oe_n[0] && pin_out[0] == lcd_common_in[0] && port_input_level[0] == 1'b0))
      else $error("LCD common not routed to its pin");

   read_wait_a: assert property (
      @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite) |=> (!hreadyout ##1 hreadyout))
      else $error("read did not answer after one wait state");

   write_read_c: cover property (
      @(posedge hclk) disable iff (!hresetn)
      (state_q == lsp_pkg::LSP_ST_WRITE) ##1 (state_q == lsp_pkg::LSP_ST_RD_FETCH));

   rmw_read_c: cover property (
      @(posedge hclk) disable iff (!hresetn)
      (state_q == lsp_pkg::LSP_ST_RD_FETCH && rmw_q && dir_q != '1));

   float_c: cover property (
      @(posedge hclk) disable iff (!hresetn)
      (standby_entry && float_en && dir_q != '0));

   lcd_c: cover property (
      @(posedge hclk) disable iff (!hresetn)
      (comsel_q != '0 && lcd_port_input_control && !standby_entry));

endmodule // lsp_port

// ===== rtl/lsp_sync.sv
module lsp_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1_q;

   if (WIDTH < 1) begin : g_width_check
      $error("lsp_sync: WIDTH must be at least 1");
   end

   // First stage is read by the second stage only
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stage1_q <= '0;
         sync_out <= '0;
      end else begin
         stage1_q <= async_in;
         sync_out <= stage1_q;
      end
   end

endmodule // lsp_sync
